// ---- core/dofs_band.sv ----
// Band check: value within centre plus or minus width times reference.
`timescale 1ns/1ps
module dofs_band
  import dofs_pkg::*;
(
  input wire logic [15:0] value_in,
  input wire logic [15:0] centre_in,
  input wire logic [DOFS_PCT_W+1:0] width_in,
  input wire logic [15:0] reference_in,
  output logic inside_out
);
  logic [27:0] prod;
  logic [17:0] span;
  logic [17:0] low;
  logic [17:0] high;
  always_comb begin
    prod = 28'(reference_in) * 28'(width_in);
    span = 18'(prod / 28'(DOFS_PCT_SCALE));
    // saturating lower bound
    // Lower bound saturates at zero; both ends are inside.
    low = (span > 18'(centre_in)) ? 18'h0 : 18'(centre_in) - span;
    high = 18'(centre_in) + span;
    inside_out = (18'(value_in) >= low) && (18'(value_in) <= high);
  end
endmodule // dofs_band

// ---- core/dofs_hyst.sv ----
// Level detector with hysteresis below the detection value.
`timescale 1ns/1ps
module dofs_hyst
  import dofs_pkg::*;
(
  input wire logic [15:0] value_in,
  input wire logic [15:0] level_in,
  input wire logic [DOFS_PCT_W+1:0] hyst_in,
  input wire logic state_in,
  output logic next_out
);
  logic [27:0] prod;
  logic [16:0] drop;
  logic [15:0] release_lvl;
  always_comb begin
    prod = 28'(level_in) * 28'(hyst_in);
    drop = 17'(prod / 28'(DOFS_PCT_SCALE));
    // A factor above 100 percent would push the release level below zero.
    release_lvl = (drop > 17'(level_in)) ? 16'h0 : 16'(17'(level_in) - drop);
    if (value_in > level_in) begin
      next_out = 1'b1;
    end else if (value_in < release_lvl) begin
      next_out = 1'b0;
    end else begin
      next_out = state_in;
    end
  end
endmodule // dofs_hyst

// ---- core/dofs_pkg.sv ----
// Package with widths, function codes and scaling for the output selector.
package dofs_pkg;
  localparam int DOFS_FREQ_W = 16;
  localparam int DOFS_CUR_W = 16;
  localparam int DOFS_AI_W = 12;
  localparam int DOFS_TIME_W = 16;
  localparam int DOFS_PCT_W = 8;
  localparam int DOFS_CODE_W = 6;
  // Band and hysteresis factors are in tenths of a percent (0 to 1023).
  localparam int DOFS_PCT_SCALE = 1000;
  localparam logic [DOFS_CODE_W-1:0] FN_AI_COMPARE = 6'h10;
  localparam logic [DOFS_CODE_W-1:0] FN_UPPER_LIMIT = 6'h11;
  localparam logic [DOFS_CODE_W-1:0] FN_LOWER_LIMIT = 6'h12;
  localparam logic [DOFS_CODE_W-1:0] FN_UNDERVOLT = 6'h13;
  localparam logic [DOFS_CODE_W-1:0] FN_COMM = 6'h14;
  localparam logic [DOFS_CODE_W-1:0] FN_POSITION_DONE = 6'h15;
  localparam logic [DOFS_CODE_W-1:0] FN_PROXIMITY = 6'h16;
  localparam logic [DOFS_CODE_W-1:0] FN_ZERO_SPEED = 6'h17;
  localparam logic [DOFS_CODE_W-1:0] FN_POWERON_TIME = 6'h18;
  localparam logic [DOFS_CODE_W-1:0] FN_FREQ_DETECT = 6'h19;
  localparam logic [DOFS_CODE_W-1:0] FN_FREQ_BAND_ONE = 6'h1A;
  localparam logic [DOFS_CODE_W-1:0] FN_FREQ_BAND_TWO = 6'h1B;
  localparam logic [DOFS_CODE_W-1:0] FN_CUR_BAND_ONE = 6'h1C;
  localparam logic [DOFS_CODE_W-1:0] FN_CUR_BAND_TWO = 6'h1D;
  localparam logic [DOFS_CODE_W-1:0] FN_TIMING = 6'h1E;
  localparam logic [1:0] LOWER_ACT_RUN_LOWER = 2'h0;
  localparam logic [1:0] LOWER_ACT_STOP = 2'h1;
  localparam logic [1:0] LOWER_ACT_RUN_ZERO = 2'h2;
  localparam logic DOFS_OUT_RESET = 1'h0;
  localparam logic DOFS_COMM_RESET = 1'h0;
  localparam logic DOFS_HYST_RESET = 1'h0;
endpackage

// ---- core/dofs_selector.sv ----
// Function selector for one multi-function digital output terminal.
`timescale 1ns/1ps
module dofs_selector
  import dofs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [DOFS_CODE_W-1:0] function_code_in,
  input wire logic [DOFS_AI_W-1:0] analog_input_one_in,
  input wire logic [DOFS_AI_W-1:0] analog_input_two_in,
  input wire logic [DOFS_FREQ_W-1:0] running_freq_in,
  input wire logic [DOFS_FREQ_W-1:0] upper_frequency_limit_in,
  input wire logic [DOFS_FREQ_W-1:0] lower_frequency_limit_in,
  input wire logic [1:0] below_lower_limit_action_in,
  input wire logic undervoltage_in,
  input wire logic comm_write_in,
  input wire logic comm_data_in,
  input wire logic positioning_done_in,
  input wire logic proximity_in,
  input wire logic running_in,
  input wire logic [DOFS_TIME_W-1:0] accumulated_poweron_time_in,
  input wire logic [DOFS_TIME_W-1:0] poweron_time_threshold_in,
  input wire logic [DOFS_FREQ_W-1:0] freq_detect_two_value_in,
  input wire logic [DOFS_PCT_W+1:0] freq_detect_two_hysteresis_in,
  input wire logic [DOFS_FREQ_W-1:0] maximum_frequency_in,
  input wire logic [DOFS_FREQ_W-1:0] freq_reach_one_value_in,
  input wire logic [DOFS_PCT_W+1:0] freq_reach_one_width_in,
  input wire logic [DOFS_FREQ_W-1:0] freq_reach_two_value_in,
  input wire logic [DOFS_PCT_W+1:0] freq_reach_two_width_in,
  input wire logic [DOFS_CUR_W-1:0] output_current_in,
  input wire logic [DOFS_CUR_W-1:0] rated_motor_current_in,
  input wire logic [DOFS_CUR_W-1:0] current_reach_one_level_in,
  input wire logic [DOFS_PCT_W+1:0] current_reach_one_width_in,
  input wire logic [DOFS_CUR_W-1:0] current_reach_two_level_in,
  input wire logic [DOFS_PCT_W+1:0] current_reach_two_width_in,
  input wire logic timing_function_enable_in,
  input wire logic [DOFS_TIME_W-1:0] current_run_time_in,
  input wire logic [DOFS_TIME_W-1:0] timing_duration_in,
  output logic terminal_out,
  output logic comm_state_out
);
  typedef struct packed {
    logic out;
    logic comm;
    logic hyst;
  } dofs_state_type;

  dofs_state_type state_q;
  dofs_state_type state_d;
  logic in_freq_one;
  logic in_freq_two;
  logic in_cur_one;
  logic in_cur_two;
  logic hyst_next;
  logic sel;

  dofs_band u_freq_one (
    .value_in(running_freq_in),
    .centre_in(freq_reach_one_value_in),
    .width_in(freq_reach_one_width_in),
    .reference_in(maximum_frequency_in),
    .inside_out(in_freq_one)
  );

  dofs_band u_freq_two (
    .value_in(running_freq_in),
    .centre_in(freq_reach_two_value_in),
    .width_in(freq_reach_two_width_in),
    .reference_in(maximum_frequency_in),
    .inside_out(in_freq_two)
  );

  dofs_band u_cur_one (
    .value_in(output_current_in),
    .centre_in(current_reach_one_level_in),
    .width_in(current_reach_one_width_in),
    .reference_in(rated_motor_current_in),
    .inside_out(in_cur_one)
  );

  dofs_band u_cur_two (
    .value_in(output_current_in),
    .centre_in(current_reach_two_level_in),
    .width_in(current_reach_two_width_in),
    .reference_in(rated_motor_current_in),
    .inside_out(in_cur_two)
  );

  dofs_hyst u_detect (
    .value_in(running_freq_in),
    .level_in(freq_detect_two_value_in),
    .hyst_in(freq_detect_two_hysteresis_in),
    .state_in(state_q.hyst),
    .next_out(hyst_next)
  );

  always_comb begin
    state_d = state_q;
    if (comm_write_in) begin
      state_d.comm = comm_data_in;
    end
    // The detector tracks the frequency even while another code is chosen.
    state_d.hyst = hyst_next;
    case (function_code_in)
      FN_AI_COMPARE: sel = analog_input_one_in > analog_input_two_in;
      FN_UPPER_LIMIT: sel = running_in &&
        (running_freq_in >= upper_frequency_limit_in);
      FN_LOWER_LIMIT: begin
        if (below_lower_limit_action_in == LOWER_ACT_STOP) begin
          sel = 1'b0;
        end else if (below_lower_limit_action_in == LOWER_ACT_RUN_LOWER ||
            below_lower_limit_action_in == LOWER_ACT_RUN_ZERO) begin
          sel = running_in &&
            (running_freq_in <= lower_frequency_limit_in);
        end else begin
          sel = 1'b0;
        end
      end
      FN_UNDERVOLT: sel = undervoltage_in;
      FN_COMM: sel = state_d.comm;
      FN_POSITION_DONE: sel = positioning_done_in;
      FN_PROXIMITY: sel = proximity_in;
      FN_ZERO_SPEED: sel = !running_in ||
        (running_freq_in == {DOFS_FREQ_W{1'b0}});
      FN_POWERON_TIME: sel =
        accumulated_poweron_time_in > poweron_time_threshold_in;
      FN_FREQ_DETECT: sel = hyst_next;
      FN_FREQ_BAND_ONE: sel = in_freq_one;
      FN_FREQ_BAND_TWO: sel = in_freq_two;
      FN_CUR_BAND_ONE: sel = in_cur_one;
      FN_CUR_BAND_TWO: sel = in_cur_two;
      FN_TIMING: sel = timing_function_enable_in &&
        (current_run_time_in >= timing_duration_in);
      default: sel = 1'b0;
    endcase
    state_d.out = sel;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_q.out <= DOFS_OUT_RESET;
      state_q.comm <= DOFS_COMM_RESET;
      state_q.hyst <= DOFS_HYST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign terminal_out = state_q.out;
  assign comm_state_out = state_q.comm;
endmodule // dofs_selector

// ---- sim/dofs_load.sv ----
// Model of the equipment wired to the output terminal.
`timescale 1ns/1ps
module dofs_load (
  input wire logic sys_clk_in,
  input wire logic terminal_in,
  output logic [15:0] pulses_out
);
  logic [15:0] count_q = 16'h0;
  // Counts the cycles the terminal is active, like an hour meter.
  always @(posedge sys_clk_in) begin
    if (terminal_in === 1'b1) count_q <= count_q + 16'h1;
  end
  assign pulses_out = count_q;
endmodule // dofs_load

// ---- sim/dofs_selector_props.sv ----
// Concurrent checks on the output selector ports.
`timescale 1ns/1ps
module dofs_selector_props
  import dofs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [DOFS_CODE_W-1:0] function_code_in,
  input wire logic [1:0] below_lower_limit_action_in,
  input wire logic undervoltage_in,
  input wire logic comm_write_in,
  input wire logic comm_data_in,
  input wire logic positioning_done_in,
  input wire logic proximity_in,
  input wire logic running_in,
  input wire logic timing_function_enable_in,
  input wire logic terminal_out,
  input wire logic comm_state_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  undervolt_follow_a: assert property (
    function_code_in == FN_UNDERVOLT
    |=> terminal_out == $past(undervoltage_in))
    else $error("undervoltage output wrong");
  comm_select_a: assert property (
    function_code_in == FN_COMM |=> terminal_out == comm_state_out)
    else $error("remote state not on terminal");
  position_follow_a: assert property (
    function_code_in == FN_POSITION_DONE
    |=> terminal_out == $past(positioning_done_in)) else $error("position");
  proximity_follow_a: assert property (
    function_code_in == FN_PROXIMITY |=> terminal_out == $past(proximity_in))
    else $error("proximity output wrong");
  lower_stop_a: assert property (
    function_code_in == FN_LOWER_LIMIT
    && below_lower_limit_action_in == LOWER_ACT_STOP |=> !terminal_out)
    else $error("lower limit output with stop action");
  zero_stopped_a: assert property (
    function_code_in == FN_ZERO_SPEED && !running_in |=> terminal_out)
    else $error("zero speed output low while stopped");
  comm_latch_a: assert property (
    comm_write_in |=> comm_state_out == $past(comm_data_in))
    else $error("remote bit not latched");
  bad_code_a: assert property (
    function_code_in < FN_AI_COMPARE || function_code_in > FN_TIMING
    |=> !terminal_out) else $error("output high on unused code");
  timing_off_a: assert property (
    function_code_in == FN_TIMING && !timing_function_enable_in
    |=> !terminal_out) else $error("timing output high while disabled");
endmodule // dofs_selector_props
bind dofs_selector dofs_selector_props i_dofs_selector_props (.*);

// ---- sim/dofs_selector_tb.sv ----
// Randomised self-checking bench for the output function selector.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin n_errors++; \
  $display("wrong value %s exp %b got %b", nm, e, s); end end
module dofs_selector_tb;
  import dofs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] f, up, lo, dv, r1v, r2v, cur, c1l, c2l, maxf, rated;
  logic [3:0] acc, thr, rt, dur;
  logic [8:0] dh, r1w, r2w, c1w, c2w;
  logic [5:0] code;
  logic [2:0] ai1, ai2;
  logic [1:0] act;
  logic uv, cw, cd, pos, prox, run, tfe, terminal_out, comm_state_out;
  logic exp_q = 1'b0, hyst_q = 1'b0, comm_q = 1'b0;
  int seed = 98584, n_errors = 0, checks = 0, cyc = 0, n_high = 0;
  logic [15:0] pulses;
  always #20 sys_clk_in = ~sys_clk_in;
  dofs_selector i_dofs_selector (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .function_code_in(code), .analog_input_one_in({9'h0, ai1}),
    .analog_input_two_in({9'h0, ai2}), .running_freq_in({8'h0, f}),
    .upper_frequency_limit_in({8'h0, up}),
    .lower_frequency_limit_in({8'h0, lo}),
    .below_lower_limit_action_in(act), .undervoltage_in(uv),
    .comm_write_in(cw), .comm_data_in(cd), .positioning_done_in(pos),
    .proximity_in(prox), .running_in(run), .timing_function_enable_in(tfe),
    .accumulated_poweron_time_in({12'h0, acc}),
    .poweron_time_threshold_in({12'h0, thr}),
    .freq_detect_two_value_in({8'h0, dv}),
    .freq_detect_two_hysteresis_in({1'h0, dh}),
    .maximum_frequency_in({8'h0, maxf}), .freq_reach_one_value_in({8'h0, r1v}),
    .freq_reach_one_width_in({1'h0, r1w}),
    .freq_reach_two_value_in({8'h0, r2v}),
    .freq_reach_two_width_in({1'h0, r2w}), .output_current_in({8'h0, cur}),
    .rated_motor_current_in({8'h0, rated}),
    .current_reach_one_level_in({8'h0, c1l}),
    .current_reach_one_width_in({1'h0, c1w}),
    .current_reach_two_level_in({8'h0, c2l}),
    .current_reach_two_width_in({1'h0, c2w}),
    .current_run_time_in({12'h0, rt}), .timing_duration_in({12'h0, dur}),
    .terminal_out(terminal_out), .comm_state_out(comm_state_out));
  dofs_load i_dofs_load (.sys_clk_in(sys_clk_in), .terminal_in(terminal_out),
    .pulses_out(pulses));
  function automatic logic band(int v, int c, int w, int r);
    int s;
    s = r * w / DOFS_PCT_SCALE;
    return v >= (c > s ? c - s : 0) && v <= c + s;
  endfunction
  function automatic int rel(int v, int h);
    int d;
    d = v * h / DOFS_PCT_SCALE;
    return d > v ? 0 : v - d;
  endfunction
  task automatic drive();
    logic [7:0] fr;
    code = 6'(14 + {$random(seed)} % 18);
    {fr, up, lo, dv, r1v, r2v, cur, c1l} = {$random(seed), $random(seed)};
    {c2l, maxf, rated, acc, thr, rt, dur} = 40'({$random(seed), $random(seed)});
    {dh, r1w, r2w} = 27'($random(seed));
    {c1w, c2w, ai1, ai2, act} = 26'($random(seed));
    // Action 3 pins the frequency to zero so the zero speed case is reached.
    f = (act == 2'h3) ? 8'h0 : fr;
    {uv, cw, cd, pos, prox, run, tfe} = 7'($random(seed));
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    logic e;
    logic c;
    logic h;
    cyc++;
    if (cyc > 1) begin
      `CHK("terminal_out", exp_q, terminal_out)
      `CHK("comm_state_out", comm_q, comm_state_out)
      if (exp_q) n_high++;
    end
    c = cw ? cd : comm_q;
    h = f > dv ? 1'b1 : (f < rel(dv, dh) ? 1'b0 : hyst_q);
    case (code)
      FN_AI_COMPARE: e = ai1 > ai2;
      FN_UPPER_LIMIT: e = run && f >= up;
      FN_LOWER_LIMIT: e = run && f <= lo && (act == 2'h0 || act == 2'h2);
      FN_UNDERVOLT: e = uv;
      FN_COMM: e = c;
      FN_POSITION_DONE: e = pos;
      FN_PROXIMITY: e = prox;
      FN_ZERO_SPEED: e = !run || f == 8'h0;
      FN_POWERON_TIME: e = acc > thr;
      FN_FREQ_DETECT: e = h;
      FN_FREQ_BAND_ONE: e = band(f, r1v, r1w, maxf);
      FN_FREQ_BAND_TWO: e = band(f, r2v, r2w, maxf);
      FN_CUR_BAND_ONE: e = band(cur, c1l, c1w, rated);
      FN_CUR_BAND_TWO: e = band(cur, c2l, c2w, rated);
      FN_TIMING: e = tfe && rt >= dur;
      default: e = 1'b0;
    endcase
    exp_q = srst_in ? 1'b0 : e;
    comm_q = srst_in ? 1'b0 : c;
    hyst_q = srst_in ? 1'b0 : h;
    if (cyc == 4000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    drive();
    repeat (5) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk_in);
      #1 drive();
      srst_in = (i == 1500) ? 1'b1 : 1'b0;
    end
    `CHK("pulses_out", 16'(n_high), pulses)
    print_verdict();
  end
endmodule // dofs_selector_tb
